// *** flash_mode_select.sv ***
// flash mode select: io-space mode switch and program-space register overlay
`default_nettype none
// Function
// - any io write to the mode location selects register mode, data ignored; the mode is kept when io_rd_i is also high
// - any io read of the mode location selects array mode, data undefined; the mode is kept when io_wr_i is also high
// - segment control reachable only in register mode, else array is accessed
// - segment control at program address zero with its documented fields
// - reset clears all segment control fields; mode location has no defined value
module flash_mode_select (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  // io space access
  input  wire logic        io_rd_i,
  input  wire logic        io_wr_i,
  input  wire logic [15:0] io_addr_i,
  output logic      [15:0] io_rdata_o,
  // program space access
  input  wire logic        prog_rd_i,
  input  wire logic        prog_wr_i,
  input  wire logic [15:0] prog_addr_i,
  input  wire logic [15:0] prog_wdata_i,
  output logic      [15:0] prog_rdata_o,
  // flash array side
  output logic             array_rd_o,
  output logic             array_wr_o,
  input  wire logic [15:0] array_rdata_i,
  // control fields to programming logic
  output logic             register_mode_o,
  output logic      [7:0]  segment_select_bits_o,
  output logic             unlock_key_hi_o,
  output logic             unlock_key_lo_o,
  output logic             verify_ctl_hi_o,
  output logic             verify_ctl_lo_o,
  output logic      [1:0]  write_erase_o,
  output logic             execute_bit_o
);
  // ****************************************
  // access decode helpers
  // ****************************************
  typedef enum logic [1:0] {
    IO_IDLE  = 2'b00,
    IO_READ  = 2'b01,
    IO_WRITE = 2'b10,
    IO_BOTH  = 2'b11
  } io_access_t;

  // full address compare
  function automatic logic addr_match(input logic [15:0] a, input logic [15:0] b);
    addr_match = (a == b);
  endfunction

  // kind of io access from the two strobes
  function automatic io_access_t io_access_kind(input logic wr, input logic rd);
    io_access_t kind;
    case ({wr, rd})
      2'b01: begin
        kind = IO_READ;
      end
      2'b10: begin
        kind = IO_WRITE;
      end
      2'b11: begin
        kind = IO_BOTH;
      end
      default: begin
        kind = IO_IDLE;
      end
    endcase
    io_access_kind = kind;
  endfunction

  // segment control overlay hit
  function automatic logic overlay_hit(input flash_mode_pkg::flash_mode_t m,
                                       input logic [15:0]             a);
    overlay_hit = (m == flash_mode_pkg::MODE_REGISTER) &&
                  addr_match(a, flash_mode_pkg::SEG_CTRL_PROG_ADDR);
  endfunction

  // ****************************************
  // io access decode
  // ****************************************
  logic       mode_hit;
  io_access_t io_kind;

  assign mode_hit = addr_match(io_addr_i, flash_mode_pkg::MODE_SELECT_IO_ADDR);
  assign io_kind  = io_access_kind(io_wr_i, io_rd_i);

  // ****************************************
  // mode flag
  // ****************************************
  flash_mode_pkg::flash_mode_t mode;
  flash_mode_pkg::flash_mode_t next_mode;

  always_comb begin
    next_mode = mode;
    if (ce_i && mode_hit) begin
      case (io_kind)
        IO_WRITE: begin
          next_mode = flash_mode_pkg::MODE_REGISTER;
        end
        IO_READ: begin
          next_mode = flash_mode_pkg::MODE_ARRAY;
        end
        default: begin
          // both strobes together change nothing
          next_mode = mode;
        end
      endcase
    end
  end

  // single flag, arbitrary reset value
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode <= flash_mode_pkg::MODE_RESET;
    end else begin
      mode <= next_mode;
    end
  end

  // ****************************************
  // io read data
  // ****************************************
  logic [15:0] io_rdata;
  logic [15:0] next_io_rdata;

  // fixed word, value undefined
  always_comb begin
    next_io_rdata = io_rdata;
    if (ce_i && mode_hit && (io_kind == IO_READ)) begin
      next_io_rdata = flash_mode_pkg::IO_RDATA_VALUE;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      io_rdata <= flash_mode_pkg::IO_RDATA_RESET;
    end else begin
      io_rdata <= next_io_rdata;
    end
  end

  assign io_rdata_o = io_rdata;

  // ****************************************
  // program space decode
  // ****************************************
  logic        reg_sel;
  logic        seg_wr;
  logic [15:0] seg_ctrl;

  // overlay only in register mode
  assign reg_sel = overlay_hit(mode, prog_addr_i);
  assign seg_wr  = prog_wr_i && reg_sel;

  // ****************************************
  // segment control register
  // ****************************************
  flash_seg_ctrl_reg flash_seg_ctrl_reg_i (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .ce_i    (ce_i),
    .wr_i    (seg_wr),
    .wdata_i (prog_wdata_i),
    .value_o (seg_ctrl)
  );

  // ****************************************
  // array requests
  // ****************************************
  // overlay hides the array at address zero
  assign array_rd_o = prog_rd_i && !reg_sel;
  assign array_wr_o = prog_wr_i && !reg_sel;

  // ****************************************
  // program read data
  // ****************************************
  logic [15:0] prog_rdata;
  logic [15:0] next_prog_rdata;

  always_comb begin
    next_prog_rdata = prog_rdata;
    if (ce_i && prog_rd_i) begin
      if (reg_sel) begin
        next_prog_rdata = seg_ctrl;
      end else begin
        next_prog_rdata = array_rdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prog_rdata <= flash_mode_pkg::PROG_RDATA_RESET;
    end else begin
      prog_rdata <= next_prog_rdata;
    end
  end

  assign prog_rdata_o = prog_rdata;

  // ****************************************
  // field outputs
  // ****************************************
  assign register_mode_o       = (mode == flash_mode_pkg::MODE_REGISTER);

  // segment control fields
  assign segment_select_bits_o =
    seg_ctrl[flash_mode_pkg::SEG_SEL_MSB:flash_mode_pkg::SEG_SEL_LSB];
  assign unlock_key_hi_o       = seg_ctrl[flash_mode_pkg::KEY_HI_BIT];
  assign unlock_key_lo_o       = seg_ctrl[flash_mode_pkg::KEY_LO_BIT];
  assign verify_ctl_hi_o       = seg_ctrl[flash_mode_pkg::VERIFY_HI_BIT];
  assign verify_ctl_lo_o       = seg_ctrl[flash_mode_pkg::VERIFY_LO_BIT];
  assign write_erase_o         =
    seg_ctrl[flash_mode_pkg::WR_ERASE_MSB:flash_mode_pkg::WR_ERASE_LSB];
  assign execute_bit_o         = seg_ctrl[flash_mode_pkg::EXECUTE_BIT];

endmodule
`default_nettype wire

// *** flash_mode_pkg.sv ***
// package: offsets, field layout and reset values of the flash mode select block
`default_nettype none
package flash_mode_pkg;
  // ****************************************
  // address map
  // ****************************************
  localparam logic [15:0] MODE_SELECT_IO_ADDR = 16'hff0f;
  localparam logic [15:0] SEG_CTRL_PROG_ADDR  = 16'h0000;
  // ****************************************
  // segment control fields
  // ****************************************
  localparam int SEG_SEL_MSB    = 15;
  localparam int SEG_SEL_LSB    = 8;
  localparam int RESERVED_BIT   = 7;
  localparam int KEY_HI_BIT     = 6;
  localparam int KEY_LO_BIT     = 5;
  localparam int VERIFY_HI_BIT  = 4;
  localparam int VERIFY_LO_BIT  = 3;
  localparam int WR_ERASE_MSB   = 2;
  localparam int WR_ERASE_LSB   = 1;
  localparam int EXECUTE_BIT    = 0;
  localparam logic [15:0] SEG_CTRL_MASK  = 16'hff7f;
  localparam logic [15:0] SEG_CTRL_RESET = 16'h0000;
  // ****************************************
  // read data
  // ****************************************
  localparam logic [15:0] PROG_RDATA_RESET = 16'h0000;
  localparam logic [15:0] IO_RDATA_RESET   = 16'h0000;
  localparam logic [15:0] IO_RDATA_VALUE   = 16'h0000;
  // ****************************************
  // modes
  // ****************************************
  typedef enum logic {
    MODE_ARRAY    = 1'b0,
    MODE_REGISTER = 1'b1
  } flash_mode_t;
  localparam flash_mode_t MODE_RESET = MODE_ARRAY;
endpackage
`default_nettype wire

// *** flash_seg_ctrl_reg.sv ***
// segment control register storage
`default_nettype none
module flash_seg_ctrl_reg (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  // write port
  input  wire logic        wr_i,
  input  wire logic [15:0] wdata_i,
  // contents
  output logic      [15:0] value_o
);
  logic [15:0] value;
  logic [15:0] next_value;

  always_comb begin
    next_value = value;
    if (ce_i && wr_i) begin
      next_value = wdata_i & flash_mode_pkg::SEG_CTRL_MASK;
    end
  end

  // reset clears every defined field
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      value <= flash_mode_pkg::SEG_CTRL_RESET;
    end else begin
      value <= next_value;
    end
  end

  assign value_o = value;
endmodule
`default_nettype wire

// *** flash_array_model.sv ***
// flash array model: word pattern from address
`default_nettype none
module flash_array_model (
  input  wire logic        array_rd_i,
  input  wire logic [15:0] addr_i,
  output logic      [15:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // inverse pattern when not read
  assign rdata_o = array_rd_i ? addr_i ^ 16'ha5a5 : ~(addr_i ^ 16'ha5a5);
endmodule
`default_nettype wire

// *** flash_mode_props.sv ***
// checker: mode switch and overlay properties
`default_nettype none
module flash_mode_props (
  input wire logic        mclk_i, rstn_i, ce_i, io_rd_i, io_wr_i, prog_wr_i,
  input wire logic [15:0] io_addr_i, prog_addr_i, prog_wdata_i,
  input wire logic        register_mode_o, array_rd_o, array_wr_o, prog_rd_i,
  input wire logic [7:0]  segment_select_bits_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire logic hit = ce_i && io_addr_i == flash_mode_pkg::MODE_SELECT_IO_ADDR;
  wire logic ovl = register_mode_o && prog_addr_i == flash_mode_pkg::SEG_CTRL_PROG_ADDR;
  wire logic [7:0] wsel = prog_wdata_i[15:8];
  sequence s_sel_reg; hit && io_wr_i && !io_rd_i; endsequence
  sequence s_sel_arr; hit && io_rd_i && !io_wr_i; endsequence
  sequence s_seg_wr; ce_i && prog_wr_i && ovl; endsequence
  property p_mode_hold; !(hit && (io_rd_i || io_wr_i)) |=> $stable(register_mode_o); endproperty
  property p_seg_land; s_seg_wr |=> segment_select_bits_o == $past(wsel); endproperty
  property p_reset_seg; disable iff (1'b0) !rstn_i |-> segment_select_bits_o == 8'h00; endproperty
  a_write_enters_reg: assert property (s_sel_reg |=> register_mode_o)
    else $error("io write did not select register mode");
  a_read_enters_arr: assert property (s_sel_arr |=> !register_mode_o)
    else $error("io read did not select array mode");
  a_mode_flag_holds: assert property (p_mode_hold)
    else $error("mode changed without a mode access");
  a_overlay_blocks_arr: assert property (ovl |-> !array_rd_o && !array_wr_o)
    else $error("array reached while overlay active");
  a_array_passes: assert property (!register_mode_o && prog_rd_i |-> array_rd_o)
    else $error("array read blocked in array mode");
  a_seg_write_lands: assert property (p_seg_land)
    else $error("segment select not written");
  a_reset_clears_seg: assert property (p_reset_seg)
    else $error("segment select not cleared in reset");
endmodule
bind flash_mode_select flash_mode_props flash_mode_props_i (.*);
`default_nettype wire

// *** flash_mode_select_bench.sv ***
// bench: random and corner accesses to the flash mode select block
`default_nettype none
module flash_mode_select_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i, rstn_i, ce_i, io_rd_i, io_wr_i, prog_rd_i, prog_wr_i, mode;
  logic [15:0] io_addr_i, prog_addr_i, prog_wdata_i, io_rdata_o, prog_rdata_o;
  logic [15:0] array_rdata_i, seg, rd, ior;
  logic array_rd_o, array_wr_o, register_mode_o, unlock_key_hi_o, unlock_key_lo_o;
  logic verify_ctl_hi_o, verify_ctl_lo_o, execute_bit_o;
  logic [7:0] segment_select_bits_o;
  logic [1:0] write_erase_o;
  int failures, n_checks;
  wire logic [15:0] fields = {segment_select_bits_o, 1'b0, unlock_key_hi_o, unlock_key_lo_o,
                              verify_ctl_hi_o, verify_ctl_lo_o, write_erase_o, execute_bit_o};
  flash_mode_select flash_mode_select_i (.*);
  flash_array_model flash_array_model_i (.array_rd_i(array_rd_o), .addr_i(prog_addr_i),
                                         .rdata_o(array_rdata_i));
  task automatic chk(input string n, input logic [15:0] g, e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // op is {io_rd, io_wr, prog_rd, prog_wr}
  task automatic acc(input logic [3:0] op, input logic [15:0] a, d, input logic ce);
    logic hit;
    hit = mode && a == 16'h0000;
    @(negedge mclk_i);
    {io_rd_i, io_wr_i, prog_rd_i, prog_wr_i} = op;
    {io_addr_i, prog_addr_i, prog_wdata_i, ce_i} = {a, a, d, ce};
    #1 chk("array_rd", 16'(array_rd_o), 16'(op[1] && !hit));
    chk("array_wr", 16'(array_wr_o), 16'(op[0] && !hit));
    @(negedge mclk_i);
    {io_rd_i, io_wr_i, prog_rd_i, prog_wr_i} = 4'h0;
    if (ce && op[0] && hit) seg = d & 16'hff7f;
    if (ce && op[1]) rd = hit ? seg : a ^ 16'ha5a5;
    if (ce && a == 16'hff0f && op[3] != op[2]) mode = op[2];
    if (ce && a == 16'hff0f && op == 4'b1000) ior = flash_mode_pkg::IO_RDATA_VALUE;
    chk("mode", 16'(register_mode_o), 16'(mode));
    chk("seg", fields, seg);
    chk("prog_rdata", prog_rdata_o, rd);
    chk("io_rdata", io_rdata_o, ior);
  endtask
  initial begin
    mclk_i = 0;
    forever #10 mclk_i = ~mclk_i;
  end
  initial begin
    #20000;
    failures++;
    conclude();
  end
  initial begin
    {rstn_i, ce_i, io_rd_i, io_wr_i, prog_rd_i, prog_wr_i} = 6'b01_0000;
    {io_addr_i, prog_addr_i, prog_wdata_i, seg, rd} = '0;
    mode = flash_mode_pkg::MODE_RESET;
    ior = flash_mode_pkg::IO_RDATA_RESET;
    void'($urandom(32'h7315));
    repeat (10) @(negedge mclk_i);
    rstn_i = 1;
    chk("reset seg", fields, 16'h0000);
    acc(4'b0100, 16'hff0f, 16'h1234, 1);
    acc(4'b0001, 16'h0000, 16'hffff, 1);
    acc(4'b0010, 16'h0000, 16'h0000, 1);
    acc(4'b0001, 16'h0000, 16'h5a5a, 0);
    acc(4'b1100, 16'hff0f, 16'h0000, 1);
    acc(4'b1000, 16'hff0e, 16'h0000, 1);
    acc(4'b1000, 16'hff0f, 16'h0000, 1);
    acc(4'b0010, 16'h0000, 16'h0000, 1);
    repeat (80) acc(4'b0001 << $urandom_range(3, 0),
                    $urandom_range(1, 0) ? 16'hff0f : 16'($urandom_range(1, 0)),
                    16'($urandom), $urandom_range(7, 0) != 0);
    acc(4'b0100, 16'hff0f, 16'h0000, 1);
    acc(4'b0001, 16'h0000, 16'hc3a5, 1);
    @(negedge mclk_i);
    rstn_i = 0;
    mode = flash_mode_pkg::MODE_RESET;
    seg = flash_mode_pkg::SEG_CTRL_RESET;
    rd = flash_mode_pkg::PROG_RDATA_RESET;
    ior = flash_mode_pkg::IO_RDATA_RESET;
    repeat (2) @(negedge mclk_i);
    chk("reset seg", fields, seg);
    chk("reset mode", 16'(register_mode_o), 16'(mode));
    rstn_i = 1;
    acc(4'b0010, 16'h0000, 16'h0000, 1);
    conclude();
  end
endmodule
`default_nettype wire
